// [inc/lcdcd_cfg.svh]
// Constants of the LCD command decoder
`ifndef LCDCD_CFG_SVH
`define LCDCD_CFG_SVH
`define LCDCD_CONT_BIT 7
`define LCDCD_MODE_PAT 2'b10
`define LCDCD_PTR_PAT 2'b00
`define LCDCD_SUB_PAT 4'b1100
`define LCDCD_BANK_PAT 5'b11110
`define LCDCD_BLINK_PAT 4'b1110
`define LCDCD_LP_BIT 4
`define LCDCD_EN_BIT 3
`define LCDCD_BIAS_BIT 2
`define LCDCD_IBANK_BIT 1
`define LCDCD_OBANK_BIT 0
`define LCDCD_AB_BIT 2
`define LCDCD_RAM_DEPTH 40
`define LCDCD_STEP_STATIC 6'h08
`define LCDCD_STEP_2MUX 6'h04
`define LCDCD_STEP_3MUX 6'h03
`define LCDCD_STEP_4MUX 6'h02
`define LCDCD_DIV_NP1 92160
`define LCDCD_DIV_NP2 184320
`define LCDCD_DIV_NP3 368640
`define LCDCD_DIV_PS1 15360
`define LCDCD_DIV_PS2 30720
`define LCDCD_DIV_PS3 61440
`define LCDCD_CNT_W 19
`endif

// [inc/lcdcd_pkg.sv]
// Types of the LCD command decoder
package lcdcd_pkg;
	typedef enum logic [1:0] {
		LCDCD_PH_CMD = 2'b01,
		LCDCD_PH_DATA = 2'b10
	} lcdcd_phase_t;
	typedef enum logic [1:0] {
		LCDCD_DRV_4MUX = 2'b00,
		LCDCD_DRV_STATIC = 2'b01,
		LCDCD_DRV_2MUX = 2'b10,
		LCDCD_DRV_3MUX = 2'b11
	} lcdcd_drive_t;
	typedef struct packed {
		lcdcd_phase_t phase;
		logic power_saving_select;
		logic disp_en;
		logic half_bias;
		lcdcd_drive_t drive;
		logic [5:0] ptr;
		logic [2:0] sub;
		logic in_bank;
		logic out_bank;
		logic bank_swap_blink_flag;
		logic [1:0] blink_rate_field;
		logic [18:0] blink_cnt;
		logic blink_ph;
		logic disp_on;
		logic shown_bank;
		logic wr_valid;
		logic [5:0] wr_addr;
		logic [2:0] wr_sub;
		logic [7:0] wr_data;
		logic wr_bank;
		logic cmd_strobe;
	} lcdcd_state_t;
endpackage

// [hw/lcdcd_decoder.sv]
// Command decoder of a segment LCD driver
// Functional notes
// - Bit 7 of every command byte is the continuation flag.
// - Flag 1: next byte of the transfer is another command.
// - Flag 0: last command; later bytes are display data.
// - Mode command (bits 6:5 = 10): bit 4 picks power-saving.
// - Mode command bit 3 enables the display.
// - Mode command bit 2 picks half bias; meaningless in static.
// - Bits 1:0 pick static, 1:2, 1:3 or 1:4 multiplex.
// - Bit 6 = 0 loads six-bit RAM pointer; host keeps it 0 to 39.
// - Pattern 1100 loads three low bits into subaddress counter.
// - Bank command bit 1 picks the input bank for data.
// - Bank command bit 0 picks the bank shown on the display.
// - Bank command ignored in 1:3 and 1:4 multiplex.
// - Blink command: bit 2 bank swap, bits 1:0 off or rate.
// - 1:3 and 1:4 multiplex always blink the whole display.
// - Blink rates divide the clock per power mode table.
// - Bank-swap blinking exchanges shown bank at blink rate.
// - Data bytes go to pointer and subaddress; pointer advances, subaddress on wrap.
`timescale 1ns/10ps
`include "lcdcd_cfg.svh"
module lcdcd_decoder
	import lcdcd_pkg::*;
#(
	parameter int DIV_NP1 = `LCDCD_DIV_NP1,
	parameter int DIV_NP2 = `LCDCD_DIV_NP2,
	parameter int DIV_NP3 = `LCDCD_DIV_NP3,
	parameter int DIV_PS1 = `LCDCD_DIV_PS1,
	parameter int DIV_PS2 = `LCDCD_DIV_PS2,
	parameter int DIV_PS3 = `LCDCD_DIV_PS3
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// Received bytes from the serial slave
	input wire logic xfer_start_i,
	input wire logic byte_valid_i,
	input wire logic [7:0] byte_data_i,
	// Own hardware subaddress
	input wire logic [2:0] hw_sub_i,
	// Decoded configuration
	output logic cmd_strobe_o,
	output logic data_phase_o,
	output logic power_saving_select_o,
	output logic disp_en_o,
	output logic half_bias_o,
	output logic [1:0] drive_mode_o,
	output logic [5:0] ram_ptr_o,
	output logic [2:0] sub_cnt_o,
	output logic in_bank_o,
	output logic out_bank_o,
	output logic bank_swap_blink_flag_o,
	output logic [1:0] blink_rate_field_o,
	// Display view
	output logic blink_phase_o,
	output logic disp_on_o,
	output logic shown_bank_o,
	// Display RAM write port
	output logic wr_valid_o,
	output logic wr_sel_o,
	output logic [5:0] wr_addr_o,
	output logic [2:0] wr_sub_o,
	output logic [7:0] wr_data_o,
	output logic wr_bank_o
);

	localparam logic [5:0] RAM_DEPTH = 6'(`LCDCD_RAM_DEPTH);

	lcdcd_state_t q;
	lcdcd_state_t d;

	logic [18:0] half_lim;
	logic is_cmd;
	logic whole_blink;
	logic blink_on;
	logic [6:0] ptr_sum;
	logic [5:0] step;

	// Half a blink period, so the phase toggles twice per period
	always_comb begin
		half_lim = 19'h00000;
		case ({q.power_saving_select, q.blink_rate_field})
			3'b001: half_lim = 19'(DIV_NP1 / 2 - 1);
			3'b010: half_lim = 19'(DIV_NP2 / 2 - 1);
			3'b011: half_lim = 19'(DIV_NP3 / 2 - 1);
			3'b101: half_lim = 19'(DIV_PS1 / 2 - 1);
			3'b110: half_lim = 19'(DIV_PS2 / 2 - 1);
			3'b111: half_lim = 19'(DIV_PS3 / 2 - 1);
			default: half_lim = 19'h00000;
		endcase
	end

	// Addresses filled per data byte depend on the backplane count
	always_comb begin
		case (q.drive)
			LCDCD_DRV_STATIC: step = `LCDCD_STEP_STATIC;
			LCDCD_DRV_2MUX: step = `LCDCD_STEP_2MUX;
			LCDCD_DRV_3MUX: step = `LCDCD_STEP_3MUX;
			LCDCD_DRV_4MUX: step = `LCDCD_STEP_4MUX;
			default: step = `LCDCD_STEP_4MUX;
		endcase
	end

	assign ptr_sum = {1'b0, q.ptr} + {1'b0, step};

	always_comb begin
		d = q;
		d.wr_valid = 1'b0;
		d.cmd_strobe = 1'b0;
		is_cmd = q.phase == LCDCD_PH_CMD;

		if (xfer_start_i) begin
			// Each transfer opens with a command byte
			d.phase = LCDCD_PH_CMD;
		end else if (byte_valid_i && is_cmd) begin
			d.cmd_strobe = 1'b1;
			if (byte_data_i[`LCDCD_CONT_BIT]) begin
				d.phase = LCDCD_PH_CMD;
			end else begin
				d.phase = LCDCD_PH_DATA;
			end
			// Whole byte is in hand here, so fields change at once
			if (byte_data_i[6:5] == `LCDCD_MODE_PAT) begin
				d.power_saving_select = byte_data_i[`LCDCD_LP_BIT];
				d.disp_en = byte_data_i[`LCDCD_EN_BIT];
				d.half_bias = byte_data_i[`LCDCD_BIAS_BIT];
				d.drive = lcdcd_drive_t'(byte_data_i[1:0]);
			end else if (byte_data_i[6] == 1'b0) begin
				d.ptr = byte_data_i[5:0];
			end else if (byte_data_i[6:3] == `LCDCD_SUB_PAT) begin
				d.sub = byte_data_i[2:0];
			end else if (byte_data_i[6:2] == `LCDCD_BANK_PAT) begin
				if (q.drive == LCDCD_DRV_STATIC
					|| q.drive == LCDCD_DRV_2MUX) begin
					d.in_bank = byte_data_i[`LCDCD_IBANK_BIT];
					d.out_bank = byte_data_i[`LCDCD_OBANK_BIT];
				end
			end else if (byte_data_i[6:3] == `LCDCD_BLINK_PAT) begin
				d.bank_swap_blink_flag = byte_data_i[`LCDCD_AB_BIT];
				d.blink_rate_field = byte_data_i[1:0];
			end
		end else if (byte_valid_i) begin
			// Display data: write at pointer, then advance
			d.wr_valid = 1'b1;
			d.wr_addr = q.ptr;
			d.wr_sub = q.sub;
			d.wr_data = byte_data_i;
			d.wr_bank = q.in_bank;
			// Past the last address the next cascaded device takes over
			if (ptr_sum >= {1'b0, RAM_DEPTH}) begin
				d.ptr = 6'(ptr_sum - {1'b0, RAM_DEPTH});
				d.sub = q.sub + 3'h1;
			end else begin
				d.ptr = ptr_sum[5:0];
			end
		end

		// Blink timebase; idle when blinking is off
		if (q.blink_rate_field == 2'b00) begin
			d.blink_cnt = 19'h00000;
			d.blink_ph = 1'b0;
		end else if (q.blink_cnt >= half_lim) begin
			d.blink_cnt = 19'h00000;
			d.blink_ph = ~q.blink_ph;
		end else begin
			d.blink_cnt = q.blink_cnt + 19'h00001;
		end

		// No alternate bank exists in 1:3 and 1:4 multiplex
		whole_blink = !d.bank_swap_blink_flag
			|| d.drive == LCDCD_DRV_3MUX
			|| d.drive == LCDCD_DRV_4MUX;
		blink_on = d.blink_rate_field != 2'b00 && d.blink_ph;
		d.disp_on = d.disp_en && !(blink_on && whole_blink);
		d.shown_bank = d.out_bank ^ (blink_on && !whole_blink);
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			q <= '0;
			q.phase <= LCDCD_PH_CMD;
			q.drive <= LCDCD_DRV_4MUX;
		end else begin
			q <= d;
		end
	end

	assign cmd_strobe_o = q.cmd_strobe;
	assign data_phase_o = q.phase == LCDCD_PH_DATA;
	assign power_saving_select_o = q.power_saving_select;
	assign disp_en_o = q.disp_en;
	assign half_bias_o = q.half_bias;
	assign drive_mode_o = q.drive;
	assign ram_ptr_o = q.ptr;
	assign sub_cnt_o = q.sub;
	assign in_bank_o = q.in_bank;
	assign out_bank_o = q.out_bank;
	assign bank_swap_blink_flag_o = q.bank_swap_blink_flag;
	assign blink_rate_field_o = q.blink_rate_field;
	assign blink_phase_o = q.blink_ph;
	assign disp_on_o = q.disp_on;
	assign shown_bank_o = q.shown_bank;
	assign wr_valid_o = q.wr_valid;
	// Only the matching device stores the byte
	assign wr_sel_o = q.wr_valid && q.wr_sub == hw_sub_i;
	assign wr_addr_o = q.wr_addr;
	assign wr_sub_o = q.wr_sub;
	assign wr_data_o = q.wr_data;
	assign wr_bank_o = q.wr_bank;

endmodule

// [tb/lcdcd_asserts.sv]
// Port checker of the LCD command decoder
`timescale 1ns/10ps
module lcdcd_asserts (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic xfer_start_i,
	input wire logic byte_valid_i,
	input wire logic [7:0] byte_data_i,
	input wire logic cmd_strobe_o,
	input wire logic data_phase_o,
	input wire logic [1:0] drive_mode_o,
	input wire logic [5:0] ram_ptr_o,
	input wire logic [2:0] sub_cnt_o,
	input wire logic in_bank_o,
	input wire logic out_bank_o,
	input wire logic [1:0] blink_rate_field_o,
	input wire logic wr_valid_o,
	input wire logic [7:0] wr_data_o
);
	wire c = byte_valid_i && !xfer_start_i && !data_phase_o;
	wire [7:0] b = byte_data_i;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	cmd_strobe_a: assert property (c |=> cmd_strobe_o)
		else $error("no command strobe");
	more_cmd_a: assert property (c && b[7] |=> !data_phase_o)
		else $error("left command phase");
	last_cmd_a: assert property (c && !b[7] |=> data_phase_o)
		else $error("no data phase");
	data_route_a: assert property (byte_valid_i && !xfer_start_i &&
		data_phase_o |=> wr_valid_o && wr_data_o == $past(byte_data_i))
		else $error("data byte not written");
	ptr_load_a: assert property (c && !b[6]
		|=> ram_ptr_o == $past(byte_data_i[5:0])) else $error("bad pointer");
	sub_load_a: assert property (c && b[6:3] == 4'b1100
		|=> sub_cnt_o == $past(byte_data_i[2:0])) else $error("bad sub");
	drive_set_a: assert property (c && b[6:5] == 2'b10
		|=> drive_mode_o == $past(byte_data_i[1:0])) else $error("bad drive");
	bank_skip_a: assert property (c && b[6:2] == 5'b11110 &&
		!(^drive_mode_o) |=> $stable({in_bank_o, out_bank_o}))
		else $error("bank changed");
	blink_set_a: assert property (c && b[6:3] == 4'b1110
		|=> blink_rate_field_o == $past(byte_data_i[1:0]))
		else $error("bad blink rate");
	unknown_a: assert property (c && b[6:2] == 5'b11111
		|=> $stable({drive_mode_o, ram_ptr_o, sub_cnt_o}))
		else $error("unknown byte acted");
endmodule
bind lcdcd_decoder lcdcd_asserts lcdcd_asserts_i (.*);

// [tb/lcdcd_host.sv]
// Bus master model that sends bytes
`timescale 1ns/10ps
module lcdcd_host (
	// Clock
	input wire logic sys_clk_i,
	// Byte stream
	output logic xfer_start_o = 1'b0,
	output logic byte_valid_o = 1'b0,
	output logic [7:0] byte_data_o = 8'h00
);
	task start();
		@(posedge sys_clk_i);
		xfer_start_o <= 1'b1;
		@(posedge sys_clk_i);
		xfer_start_o <= 1'b0;
	endtask
	// Gap 0 keeps valid up; idle data is inverted, never stale
	task put(input logic [7:0] b, input int gap);
		@(posedge sys_clk_i);
		byte_valid_o <= 1'b1;
		byte_data_o <= b;
		repeat (gap) begin
			@(posedge sys_clk_i);
			byte_valid_o <= 1'b0;
			byte_data_o <= ~b;
		end
	endtask
endmodule

// [tb/tb.sv]
// Self-checking bench of the LCD command decoder
`timescale 1ns/10ps
module tb;
	logic sys_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [2:0] hs = 3'h0;
	logic xs, bv, cs, dp, ps, en, hb, ib, ob, ab, bp, dn, sb, wv, ws, wb;
	logic [1:0] dm, bf;
	logic [5:0] rp, wa;
	logic [2:0] sc, wu;
	logic [7:0] bd, wd;
	int n_errors = 0;
	int total_checks = 0;
	always #25 sys_clk_i = ~sys_clk_i;
	lcdcd_host lcdcd_host_i (.sys_clk_i(sys_clk_i), .xfer_start_o(xs),
		.byte_valid_o(bv), .byte_data_o(bd));
	lcdcd_decoder #(.DIV_NP1(16), .DIV_NP2(32), .DIV_NP3(64),
		.DIV_PS1(8), .DIV_PS2(16)) lcdcd_decoder_i (
		.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .xfer_start_i(xs),
		.byte_valid_i(bv), .byte_data_i(bd), .hw_sub_i(hs),
		.cmd_strobe_o(cs), .data_phase_o(dp), .power_saving_select_o(ps),
		.disp_en_o(en), .half_bias_o(hb), .drive_mode_o(dm),
		.ram_ptr_o(rp), .sub_cnt_o(sc), .in_bank_o(ib), .out_bank_o(ob),
		.bank_swap_blink_flag_o(ab), .blink_rate_field_o(bf),
		.blink_phase_o(bp), .disp_on_o(dn), .shown_bank_o(sb),
		.wr_valid_o(wv), .wr_sel_o(ws), .wr_addr_o(wa), .wr_sub_o(wu),
		.wr_data_o(wd), .wr_bank_o(wb));
	task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		total_checks++;
		if (s !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task cmd(input logic [7:0] b);
		lcdcd_host_i.put(b, 1);
		#1;
	endtask
	task print_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#1000000;
		n_errors++;
		print_verdict();
	end
	initial begin
		logic [7:0] r, p, s;
		int k;
		r = $urandom(32'hba0f);
		repeat (5) @(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		for (k = 0; k < 32; k++) begin
			lcdcd_host_i.start();
			cmd({3'b010, k[4:0]});
			chk("mode", {3'h1, k[4:0]}, {dp, ps, en, hb, dm});
		end
		$display("test mode done");
		lcdcd_host_i.start();
		cmd(8'hC9);
		chk("phase", 8'h00, {7'h00, dp});
		for (k = 0; k < 4; k++) begin
			cmd(8'hF8 | k[7:0]);
			chk("bank", k[7:0], {6'h00, ib, ob});
		end
		cmd(8'hC8);
		cmd(8'hF8);
		chk("bank 1:4", 8'h03, {6'h00, ib, ob});
		cmd(8'hFC);
		chk("unknown", 8'h03, {4'h0, dm, ib, ob});
		$display("test bank done");
		for (k = 0; k < 8; k++) begin
			p = $urandom % 40;
			cmd({2'b10, p[5:0]});
			cmd(8'hE0 | k[7:0]);
			chk("pointer", p, {2'b00, rp});
			chk("sub", k[7:0], {5'h00, sc});
			cmd(8'hF0 | k[7:0]);
			chk("blink", k[7:0], {5'h00, ab, bf});
		end
		// Rate 3 at normal power, half period of DIV_NP3 / 2
		s = {7'h00, bp};
		while (bp === s[0]) #50;
		k = 0;
		while (bp !== s[0] && k < 99) begin
			#50;
			k++;
		end
		chk("half period", 8'd32, k[7:0]);
		chk("shown bank", 8'h01, {7'h00, sb});
		chk("disp on", {7'h00, ~bp}, {7'h00, dn});
		$display("test blink done");
		cmd(8'h00);
		p = 8'h00;
		s = 8'h07;
		for (k = 0; k < 24; k++) begin
			r = $urandom;
			hs = s[2:0];
			if (k == 10) begin
				lcdcd_host_i.put(8'h5A, 0);
				p = p + 8'd2;
			end
			cmd(r);
			chk("wr data", r, wd);
			chk("wr addr", p, {2'b00, wa});
			chk("wr sel", {s[2:0], 5'h01}, {wu, 4'h0, ws});
			chk("wr bank", 8'h01, {7'h00, wb});
			p = p + 8'd2;
			if (p >= 8'd40) begin
				p = p - 8'd40;
				s = (s + 8'd1) & 8'h07;
			end
		end
		$display("test data done");
		print_verdict();
	end
endmodule
